// ==== shared/obs_burst_regs.svh ====
// Purpose: Offsets, field positions, reset values and counts of the register bank
// Assumes: 7-bit register addresses on the serial port
// Notes: Definitions only
`ifndef OBS_BURST_REGS_SVH
`define OBS_BURST_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SELF_CHECK_ADDR 7'h3d
`define INV_PART_ID_ADDR 7'h3f
`define PIXEL_BURST_ADDR 7'h40
`define MOTION_BURST_ADDR 7'h50
`define FW_LOAD_ADDR 7'h60
// ----------------------------------------
// Self-check fields and reset
// ----------------------------------------
`define SC_FW_BIT 7
`define SC_SLEEP_BIT 5
`define SC_TICK_HI_BIT 1
`define SC_TICK_LO_BIT 0
`define SELF_CHECK_RESET 8'h00
`define GATEWAY_RESET 8'h00
// ----------------------------------------
// Burst counts
// ----------------------------------------
`define PIX_FRAME_BYTES 12'h384
`define PIX_BURST_LEN 12'h5dc
`define MOTION_BURST_LEN 3'h7
`endif

// ==== shared/obs_burst_pkg.sv ====
// Purpose: Types of the register bank
// Assumes: Nothing beyond the register header
// Notes: Types only
`default_nettype none
package obs_burst_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_WR = 2'b11,
        ST_RD = 2'b10
    } port_state_t;
endpackage
`default_nettype wire

// ==== src/obs_burst_bank.sv ====
// Purpose: Self-check, inverted identifier, burst and download gateways on the serial port
// Assumes: Serial clock idle high, data out on falling and sampled on rising edge
// Notes: Serial port and power-down pins sampled by clk_i through two flip-flops
//
// What this block does
// - Writing 0x00 clears every self-check flag
// - Flags set by events, held until cleared
// - Bit 7 shows firmware is running
// - Bit 5 set on power-down pulse
// - Self-check register read/write, resets to 0x00
// - Register 0x3F returns inverted part identifier
// - Pixel gateway read bursts 5/3 frames
// - Motion gateway read bursts seven motion bytes
// - Write-only gateway streams firmware bytes
`timescale 1ns/10ps
`default_nettype none
`include "obs_burst_regs.svh"
module obs_burst_bank #(
    parameter logic [7:0] PART_ID = 8'h5a // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial port pins
    input wire logic ncs_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // Sensor state and events
    input wire logic power_down_n_input_i,
    input wire logic firmware_running_i,
    input wire logic frame_tick_i,
    // Motion record: status, dx, dy, quality, shutter hi, shutter lo, peak
    input wire logic [55:0] motion_rec_i,
    // Pixel stream
    input wire logic [7:0] pixel_i,
    input wire logic pixel_valid_i,
    output logic pixel_ready_o,
    // Firmware stream
    output logic [7:0] fw_data_o,
    output logic fw_valid_o,
    input wire logic fw_ready_i,
    output logic fw_overrun_o
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    logic sclk_d_ff;
    logic pd_d_ff;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= 4'hf;
            sync_ff <= 4'hf;
            sclk_d_ff <= 1'b1;
            pd_d_ff <= 1'b1;
        end else begin
            meta_ff <= {power_down_n_input_i, mosi_i, sclk_i, ncs_n_i};
            sync_ff <= meta_ff;
            sclk_d_ff <= sync_ff[1];
            pd_d_ff <= sync_ff[3];
        end
    end
    logic ncs_n_s, sclk_s, mosi_s, sclk_rise, sclk_fall, pd_rise;
    assign ncs_n_s = sync_ff[0];
    assign sclk_s = sync_ff[1];
    assign mosi_s = sync_ff[2];
    assign sclk_rise = sclk_s && !sclk_d_ff;
    assign sclk_fall = !sclk_s && sclk_d_ff;
    // A low then high level on the power-down pin counts as one pulse
    assign pd_rise = sync_ff[3] && !pd_d_ff;
    // ----------------------------------------
    // Serial framing
    // ----------------------------------------
    obs_burst_pkg::port_state_t st_ff, nxt_st;
    logic [2:0] cnt_ff;
    logic [7:0] sh_ff;
    logic [6:0] addr_ff;
    logic [7:0] sh_next;
    logic byte_done;
    assign sh_next = {sh_ff[6:0], mosi_s};
    assign byte_done = sclk_rise && (cnt_ff == 3'h7) && (st_ff != obs_burst_pkg::ST_IDLE);
    logic is_burst;
    assign is_burst = (addr_ff == `PIXEL_BURST_ADDR) || (addr_ff == `MOTION_BURST_ADDR);
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            obs_burst_pkg::ST_IDLE: begin
                if (!ncs_n_s) begin
                    nxt_st = obs_burst_pkg::ST_ADDR;
                end
            end
            obs_burst_pkg::ST_ADDR: begin
                if (byte_done) begin
                    nxt_st = sh_next[7] ? obs_burst_pkg::ST_WR : obs_burst_pkg::ST_RD;
                end
            end
            obs_burst_pkg::ST_WR: begin
                // Download keeps streaming until the frame ends
                if (byte_done && addr_ff != `FW_LOAD_ADDR) begin
                    nxt_st = obs_burst_pkg::ST_ADDR;
                end
            end
            obs_burst_pkg::ST_RD: begin
                if (byte_done && !is_burst) begin
                    nxt_st = obs_burst_pkg::ST_ADDR;
                end
            end
            default: nxt_st = obs_burst_pkg::ST_IDLE;
        endcase
        if (ncs_n_s) begin
            nxt_st = obs_burst_pkg::ST_IDLE;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= obs_burst_pkg::ST_IDLE;
            cnt_ff <= 3'h0;
            sh_ff <= 8'h00;
            addr_ff <= 7'h00;
        end else begin
            st_ff <= nxt_st;
            if (ncs_n_s) begin
                cnt_ff <= 3'h0;
            end else if (sclk_rise) begin
                cnt_ff <= cnt_ff + 3'h1;
                sh_ff <= sh_next;
            end
            if (byte_done && st_ff == obs_burst_pkg::ST_ADDR) begin
                addr_ff <= sh_next[6:0];
            end
        end
    end
    // ----------------------------------------
    // Self-check flags
    // ----------------------------------------
    logic [7:0] flags_ff;
    logic wr_chk;
    logic [7:0] set_ev;
    assign wr_chk = byte_done && st_ff == obs_burst_pkg::ST_WR && addr_ff == `SELF_CHECK_ADDR;
    always_comb begin
        set_ev = 8'h00;
        set_ev[`SC_SLEEP_BIT] = pd_rise;
        set_ev[`SC_TICK_HI_BIT] = frame_tick_i;
        set_ev[`SC_TICK_LO_BIT] = frame_tick_i;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags_ff <= `SELF_CHECK_RESET;
        end else if (wr_chk) begin
            // Written zeros clear; an event in the same cycle still wins
            flags_ff <= (flags_ff & sh_next) | set_ev;
        end else begin
            flags_ff <= flags_ff | set_ev;
        end
    end
    logic [7:0] chk_rd;
    always_comb begin
        chk_rd = 8'h00;
        chk_rd[`SC_FW_BIT] = firmware_running_i;
        chk_rd[`SC_SLEEP_BIT] = flags_ff[`SC_SLEEP_BIT];
        chk_rd[`SC_TICK_HI_BIT] = flags_ff[`SC_TICK_HI_BIT];
        chk_rd[`SC_TICK_LO_BIT] = flags_ff[`SC_TICK_LO_BIT];
    end
    // ----------------------------------------
    // Read data and bursts
    // ----------------------------------------
    logic ld;
    logic [6:0] ld_addr;
    logic [11:0] bidx_ff, ld_idx;
    logic pix_take;
    logic [7:0] rd_val;
    logic [7:0] tx_ff;
    assign ld = byte_done && ((st_ff == obs_burst_pkg::ST_ADDR && !sh_next[7])
                || (st_ff == obs_burst_pkg::ST_RD && is_burst));
    assign ld_addr = (st_ff == obs_burst_pkg::ST_ADDR) ? sh_next[6:0] : addr_ff;
    assign ld_idx = (st_ff == obs_burst_pkg::ST_ADDR) ? 12'h000 : bidx_ff;
    assign pix_take = ld && ld_addr == `PIXEL_BURST_ADDR && pixel_valid_i
                      && ld_idx < `PIX_BURST_LEN;
    always_comb begin
        rd_val = `GATEWAY_RESET;
        case (ld_addr)
            `SELF_CHECK_ADDR: rd_val = chk_rd;
            `INV_PART_ID_ADDR: rd_val = ~PART_ID;
            `PIXEL_BURST_ADDR: rd_val = pix_take ? pixel_i : `GATEWAY_RESET;
            `MOTION_BURST_ADDR: begin
                if (ld_idx < {9'h000, `MOTION_BURST_LEN}) begin
                    rd_val = motion_rec_i[8 * (6 - int'(ld_idx[2:0])) +: 8];
                end
            end
            default: rd_val = `GATEWAY_RESET;
        endcase
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_ff <= 8'h00;
            bidx_ff <= 12'h000;
            pixel_ready_o <= 1'b0;
            miso_o <= 1'b0;
            miso_oe_o <= 1'b0;
        end else begin
            pixel_ready_o <= pix_take;
            miso_oe_o <= !ncs_n_s;
            if (ld) begin
                tx_ff <= rd_val;
                // Saturates so an endless burst never wraps back to fresh data
                bidx_ff <= (ld_idx == 12'hfff) ? ld_idx : ld_idx + 12'h001;
            end else if (sclk_fall && st_ff == obs_burst_pkg::ST_RD) begin
                miso_o <= tx_ff[7];
                tx_ff <= {tx_ff[6:0], 1'b0};
            end
        end
    end
    // ----------------------------------------
    // Firmware download buffer
    // ----------------------------------------
    // Two entries: the port cannot stall, so a byte into a full buffer is lost
    logic [7:0] d1_ff;
    logic v1_ff;
    logic push, pop, fw_byte;
    assign fw_byte = byte_done && st_ff == obs_burst_pkg::ST_WR && addr_ff == `FW_LOAD_ADDR;
    assign push = fw_byte && !v1_ff;
    assign pop = fw_valid_o && fw_ready_i;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fw_data_o <= 8'h00;
            fw_valid_o <= 1'b0;
            d1_ff <= 8'h00;
            v1_ff <= 1'b0;
            fw_overrun_o <= 1'b0;
        end else begin
            if (fw_byte && v1_ff) begin
                fw_overrun_o <= 1'b1;
            end
            if (push && !pop) begin
                if (!fw_valid_o) begin
                    fw_data_o <= sh_next;
                    fw_valid_o <= 1'b1;
                end else begin
                    d1_ff <= sh_next;
                    v1_ff <= 1'b1;
                end
            end else if (!push && pop) begin
                fw_data_o <= d1_ff;
                fw_valid_o <= v1_ff;
                v1_ff <= 1'b0;
            end else if (push && pop) begin
                fw_data_o <= v1_ff ? d1_ff : sh_next;
                d1_ff <= sh_next;
            end
        end
    end
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence read_addr_s;
        byte_done && st_ff == obs_burst_pkg::ST_ADDR && !sh_next[7];
    endsequence
    sequence chk_clear_s;
        wr_chk && sh_next == 8'h00 && !pd_rise && !frame_tick_i;
    endsequence
    clear_on_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        chk_clear_s |=> flags_ff == 8'h00) else $error("flags not cleared by zero write");
    flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_ff[`SC_TICK_LO_BIT] && !wr_chk |=> flags_ff[`SC_TICK_LO_BIT])
        else $error("flag dropped without clear");
    tick_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
        frame_tick_i |=> flags_ff[`SC_TICK_HI_BIT] && flags_ff[`SC_TICK_LO_BIT])
        else $error("frame tick did not set flags");
    sleep_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pd_rise |=> flags_ff[`SC_SLEEP_BIT]) else $error("power-down pulse missed");
    fw_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        read_addr_s ##0 (sh_next[6:0] == `SELF_CHECK_ADDR)
        |=> tx_ff[7] == $past(firmware_running_i) && tx_ff[6] == 1'b0 && tx_ff[4:2] == 3'h0)
        else $error("self-check read value wrong");
    inv_id_a: assert property (@(posedge clk_i) disable iff (rst_i)
        read_addr_s ##0 (sh_next[6:0] == `INV_PART_ID_ADDR) |=> tx_ff == ~PART_ID)
        else $error("inverted identifier wrong");
    pixel_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
        read_addr_s ##0 (sh_next[6:0] == `PIXEL_BURST_ADDR && pixel_valid_i)
        |=> pixel_ready_o ##1 !pixel_ready_o) else $error("pixel not taken");
    motion_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
        read_addr_s ##0 (sh_next[6:0] == `MOTION_BURST_ADDR)
        |=> tx_ff == $past(motion_rec_i[55:48]) && bidx_ff == 12'h001)
        else $error("motion burst first byte wrong");
    fw_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fw_valid_o && !fw_ready_i |=> fw_valid_o && $stable(fw_data_o))
        else $error("firmware byte lost under stall");
endmodule
`default_nettype wire

// ==== tb/spi_host_model.sv ====
// Purpose: Serial port master that drives the register bank
// Assumes: Clock idle high, data changed on falls, read on rises
// Notes: Half period of 4 clk_i cycles, a 160 ns link clock
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    // Clock
    input wire logic clk_i,
    // Serial port
    output logic ncs_n_o,
    output logic sclk_o,
    output logic mosi_o,
    input wire logic miso_i,
    input wire logic miso_oe_i
);
    initial begin
        ncs_n_o = 1'b1;
        sclk_o = 1'b1;
        mosi_o = 1'b0;
    end
    // ------
    // Framing
    // ------
    task automatic sel();
        @(posedge clk_i);
        ncs_n_o <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic desel();
        repeat (6) @(posedge clk_i);
        ncs_n_o <= 1'b1;
        // Released line must not keep a stale bit
        mosi_o <= ~mosi_o;
        repeat (8) @(posedge clk_i);
    endtask
    // Undriven data line reads as garbage, not as the last bit
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_i);
            sclk_o <= 1'b0;
            mosi_o <= tx[i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            rx[i] = miso_oe_i ? miso_i : ~miso_i;
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench of the self-check and gateway registers
// Assumes: Serial master model stands on the port
// Notes: Pixel burst limit not reached, run would be too long
`timescale 1ns/10ps
`default_nettype none
`include "obs_burst_regs.svh"
module tb_top;
    localparam logic [7:0] PART_ID = 8'h3c; // Arbitrary value
    logic clk_i, rst_i, ncs_n, sclk, mosi, miso, miso_oe, pd_n, fw_run, tick;
    logic pix_valid, pix_ready, fw_valid, fw_ready, fw_overrun;
    logic [55:0] mrec;
    logic [7:0] pix, fw_data, rx;
    logic [7:0] popped[$];
    int error_cnt, n_compared;
    obs_burst_bank #(.PART_ID(PART_ID)) i_obs_burst_bank (
        .clk_i(clk_i), .rst_i(rst_i), .ncs_n_i(ncs_n), .sclk_i(sclk), .mosi_i(mosi),
        .miso_o(miso), .miso_oe_o(miso_oe), .power_down_n_input_i(pd_n),
        .firmware_running_i(fw_run), .frame_tick_i(tick), .motion_rec_i(mrec),
        .pixel_i(pix), .pixel_valid_i(pix_valid), .pixel_ready_o(pix_ready),
        .fw_data_o(fw_data), .fw_valid_o(fw_valid), .fw_ready_i(fw_ready),
        .fw_overrun_o(fw_overrun));
    spi_host_model i_spi_host_model (.clk_i(clk_i), .ncs_n_o(ncs_n), .sclk_o(sclk),
        .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Stream consumers: next pixel on each take, firmware bytes collected
    always @(posedge clk_i) begin
        if (fw_valid === 1'b1 && fw_ready === 1'b1) popped.push_back(fw_data);
        if (pix_ready === 1'b1) pix <= pix + 8'h01;
    end
    // ------
    // Access tasks
    // ------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        i_spi_host_model.sel();
        i_spi_host_model.xfer({1'b1, a}, r);
        i_spi_host_model.xfer(d, r);
        i_spi_host_model.desel();
    endtask
    task automatic reg_rd(input logic [6:0] a, output logic [7:0] d);
        i_spi_host_model.sel();
        i_spi_host_model.xfer({1'b0, a}, d);
        i_spi_host_model.xfer(8'h00, d);
        i_spi_host_model.desel();
    endtask
    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk_i);
        error_cnt++;
        results();
    end
    // ------
    // Tests
    // ------
    initial begin
        rst_i = 1'b1;
        {pd_n, fw_run, tick, pix_valid, fw_ready} = 5'h10;
        mrec = 56'h11223344556677;
        pix = 8'ha0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        reg_rd(`SELF_CHECK_ADDR, rx);
        chk(rx, `SELF_CHECK_RESET);
        @(posedge clk_i);
        tick <= 1'b1;
        @(posedge clk_i);
        tick <= 1'b0;
        reg_rd(`SELF_CHECK_ADDR, rx);
        chk(rx, 8'h03);
        reg_rd(`SELF_CHECK_ADDR, rx);
        chk(rx, 8'h03);
        reg_wr(`SELF_CHECK_ADDR, 8'h00);
        repeat (20) @(posedge clk_i);
        reg_rd(`SELF_CHECK_ADDR, rx);
        chk(rx, 8'h00);
        pd_n <= 1'b0;
        repeat (6) @(posedge clk_i);
        pd_n <= 1'b1;
        reg_rd(`SELF_CHECK_ADDR, rx);
        chk(rx, 8'h20);
        fw_run <= 1'b1;
        reg_rd(`SELF_CHECK_ADDR, rx);
        chk(rx, 8'ha0);
        fw_run <= 1'b0;
        reg_wr(`SELF_CHECK_ADDR, 8'h00);
        reg_rd(`SELF_CHECK_ADDR, rx);
        chk(rx, 8'h00);
        reg_wr(`INV_PART_ID_ADDR, 8'h00);
        reg_rd(`INV_PART_ID_ADDR, rx);
        chk(rx, ~PART_ID);
        reg_rd(7'h3e, rx);
        chk(rx, 8'h00);
        i_spi_host_model.sel();
        i_spi_host_model.xfer({1'b0, `MOTION_BURST_ADDR}, rx);
        for (int i = 0; i < 8; i++) begin
            i_spi_host_model.xfer(8'h00, rx);
            chk(rx, (i < 7) ? 8'(mrec >> (8 * (6 - i))) : 8'h00);
        end
        i_spi_host_model.desel();
        reg_rd(`PIXEL_BURST_ADDR, rx);
        chk(rx, `GATEWAY_RESET);
        pix_valid <= 1'b1;
        i_spi_host_model.sel();
        i_spi_host_model.xfer({1'b0, `PIXEL_BURST_ADDR}, rx);
        for (int i = 0; i < 3; i++) begin
            i_spi_host_model.xfer(8'h00, rx);
            chk(rx, 8'(8'ha0 + i));
        end
        i_spi_host_model.desel();
        i_spi_host_model.sel();
        i_spi_host_model.xfer({1'b1, `FW_LOAD_ADDR}, rx);
        i_spi_host_model.xfer(8'h81, rx);
        i_spi_host_model.xfer(8'h42, rx);
        i_spi_host_model.xfer(8'h24, rx);
        i_spi_host_model.desel();
        chk({7'h00, fw_overrun}, 8'h01);
        fw_ready <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(8'(popped.size()), 8'h02);
        chk(popped[0], 8'h81);
        chk(popped[1], 8'h42);
        chk({7'h00, fw_valid}, 8'h00);
        // Mid-run reset drops sticky state
        @(posedge clk_i);
        tick <= 1'b1;
        @(posedge clk_i);
        tick <= 1'b0;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk({7'h00, fw_overrun}, 8'h00);
        reg_rd(`SELF_CHECK_ADDR, rx);
        chk(rx, `SELF_CHECK_RESET);
        // Recovery check: clear, let a frame pass, read back
        reg_wr(`SELF_CHECK_ADDR, 8'h00);
        @(posedge clk_i);
        tick <= 1'b1;
        @(posedge clk_i);
        tick <= 1'b0;
        repeat (20) @(posedge clk_i);
        reg_rd(`SELF_CHECK_ADDR, rx);
        chk(rx, 8'h03);
        results();
    end
endmodule
`default_nettype wire
